// ==== rtl/lpw_wakeup.sv ====
// card-presence wake-up detection with its AHB-Lite register file
// assumes an 8-bit converter outside that answers meas.start with adc_done
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "lpw_defines.svh"
// What this block does
// R1 - wake-up mode entered only by writing the wake bit with all others zero
// R2 - a 32 kHz tick from a divider paces the wake-up timer
// R3 - amplitude and phase measurements, each enabled on its own
// R4 - in wake-up mode measure every period, interrupt on a difference
// R5 - reader field is on only about 20 us per measurement
// R6 - timer control picks interval 10..800 ms, default 100, and methods
// R7 - each method has config, host reference, average and result registers
// R8 - interrupt only when absolute difference is above the threshold
// R9 - reference is the running average or the host value, per method
// R10 - config holds threshold, reference choice and averaging weight
// R11 - host sets up wake-up configuration before entry, not during it
// R12 - average moves to old minus (old minus result) over weight
// R13 - averaging is done on 10 bits
// R14 - first entry seeds average from nonzero reference, else first result
// R15 - a config bit decides if an interrupting sample joins the average
// R16 - host changes timer settings only while the timer is stopped
// R17 - stop-all command halts every timer including wake-up timer
// R18 - start-timer command works outside wake-up mode and flags expiry
// R19 - 8-bit converter result stays readable in its own register
// R20 - detection flag holds until the host reads the interrupt register
// R21 - displayed average is the upper 8 bits of the accumulator
module lpw_wakeup #(
  parameter int DW = 8,
  parameter int AW = 10,
  parameter int RC_DIV = `LPW_CLK_KHZ / `LPW_RC_KHZ,
  parameter int FIELD_CYC = `LPW_FIELD_NS / `LPW_CLK_NS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // converter
  output lpw_pkg::lpw_meas_t meas,
  input wire logic adc_done,
  input wire logic [DW-1:0] adc_data,
  // host interrupt
  output logic irq
);
  if (AW != DW + 2 || RC_DIV < 2 || FIELD_CYC < 2) begin : g_chk
    $error("lpw_wakeup: unsupported parameters");
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wr_q;
  logic [7:0] wa_q;
  wire acc_ok = hsel & hready & htrans[1];
  wire [7:0] ra = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= acc_ok & hwrite;
      wa_q <= ra;
    end
  end

  wire w_op = wr_q & (wa_q == `LPW_A_OP);
  wire w_cmd = wr_q & (wa_q == `LPW_A_CMD);
  wire w_wtc = wr_q & (wa_q == `LPW_A_WTC);
  wire w_mth = wr_q & (wa_q[7:5] == `LPW_MB_HI);
  wire w_msel = wa_q[4];
  wire [1:0] w_mreg = wa_q[3:2];
  wire rd_irq = acc_ok & !hwrite & (ra == `LPW_A_IRQ);
  wire c_stop = w_cmd & (hwdata[7:0] == `LPW_CMD_STOP);
  wire c_wt = w_cmd & (hwdata[7:0] == `LPW_CMD_WT);
  wire c_def = w_cmd & (hwdata[7:0] == `LPW_CMD_DEF);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic wake;
  logic wake_q;
  logic [4:0] wtc;
  lpw_pkg::lpw_cfg_t cfg [2];
  logic [DW-1:0] refr [2];
  logic [AW-1:0] acc [2];
  logic [DW-1:0] res [2];
  logic [DW-1:0] adc_out;
  logic [2:0] irqf;
  logic [1:0] init_done;

  // any other bit set means another mode, so wake-up is left
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake <= 1'b0;
      wake_q <= 1'b0;
      wtc <= `LPW_WTC_RST;
    end else begin
      wake_q <= wake;
      if (c_def) begin
        wake <= 1'b0;
        wtc <= `LPW_WTC_RST;
      end else begin
        if (w_op)
          wake <= (hwdata == `LPW_OP_WAKE); // R1
        if (w_wtc)
          wtc <= hwdata[4:0]; // R6
      end
    end
  end

  wire wake_ent = wake & !wake_q;
  wire amp_en = wtc[`LPW_AMP_EN]; // R3
  wire ph_en = wtc[`LPW_PH_EN]; // R3

  // ----------------------------------------
  // rc tick and wake-up timer
  // ----------------------------------------
  // divider only runs with the timer, as the rc oscillator would
  logic [$clog2(RC_DIV)-1:0] rc_cnt;
  logic tmr_run;
  logic [14:0] tmr_cnt;
  logic [14:0] tmr_top;
  wire rc_tick = tmr_run & (rc_cnt == ($clog2(RC_DIV))'(RC_DIV - 1)); // R2
  wire tmr_exp = rc_tick & (tmr_cnt >= tmr_top);
  // interval in 32 kHz ticks, 32 ticks per millisecond
  localparam logic [14:0] TMR_TOP [8] = `LPW_WT_TOP;
  assign tmr_top = TMR_TOP[wtc[2:0]]; // R6
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_cnt <= '0;
      tmr_cnt <= 15'h0001;
      tmr_run <= 1'b0;
    end else begin
      if (!tmr_run || rc_tick)
        rc_cnt <= '0;
      else
        rc_cnt <= rc_cnt + 1'b1;
      if (c_stop || c_def || (!wake && wake_q)) begin
        tmr_run <= 1'b0; // R17
      end else if (wake_ent || (c_wt && !wake)) begin
        tmr_run <= 1'b1; // R18
        tmr_cnt <= 15'h0001;
      end else if (tmr_exp) begin
        tmr_cnt <= 15'h0001;
        tmr_run <= wake; // R4
      end else if (rc_tick) begin
        tmr_cnt <= tmr_cnt + 15'h0001;
      end
    end
  end

  // ----------------------------------------
  // measurement sequencer
  // ----------------------------------------
  lpw_pkg::lpw_state_t state;
  lpw_pkg::lpw_state_t next_state;
  logic sel;
  logic next_sel;
  logic got;
  logic [$clog2(FIELD_CYC)-1:0] fcnt;
  wire f_end = fcnt == ($clog2(FIELD_CYC))'(FIELD_CYC - 1);
  logic [$clog2(FIELD_CYC):0] on_cnt; // wider than fcnt, so an overrun cannot wrap unseen
  always_comb begin
    next_state = state;
    next_sel = sel;
    unique case (state)
      lpw_pkg::LPW_IDLE: begin
        if (wake && tmr_run)
          next_state = lpw_pkg::LPW_WAIT;
      end
      lpw_pkg::LPW_WAIT: begin
        if (!wake || !tmr_run) begin
          next_state = lpw_pkg::LPW_IDLE;
        end else if (tmr_exp && (amp_en || ph_en)) begin
          next_state = lpw_pkg::LPW_FIELD; // R4
          next_sel = !amp_en;
        end
      end
      lpw_pkg::LPW_FIELD: begin
        if (!wake || !tmr_run)
          next_state = lpw_pkg::LPW_IDLE; // R17
        else if (adc_done || f_end)
          next_state = lpw_pkg::LPW_EVAL; // R5
      end
      lpw_pkg::LPW_EVAL: begin
        if (!sel && ph_en && wake && tmr_run) begin
          next_state = lpw_pkg::LPW_FIELD;
          next_sel = 1'b1;
        end else begin
          next_state = lpw_pkg::LPW_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= lpw_pkg::LPW_IDLE;
      sel <= 1'b0;
      got <= 1'b0;
      fcnt <= '0;
      on_cnt <= '0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      fcnt <= (state == lpw_pkg::LPW_FIELD) ? fcnt + 1'b1 : '0;
      on_cnt <= (state == lpw_pkg::LPW_FIELD) ? on_cnt + 1'b1 : '0;
      if (state == lpw_pkg::LPW_FIELD)
        got <= adc_done;
    end
  end
  wire in_field = state == lpw_pkg::LPW_FIELD;
  wire eval = (state == lpw_pkg::LPW_EVAL) & got;
  assign meas.field_on = in_field; // R5
  assign meas.start = in_field & (fcnt == '0);
  assign meas.method = sel;

  // converter result stays visible after the field is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      adc_out <= '0;
    else if (in_field && adc_done)
      adc_out <= adc_data; // R19
  end

  // ----------------------------------------
  // per-method compare and averaging
  // ----------------------------------------
  logic [1:0] hit;
  for (genvar i = 0; i < 2; i++) begin : g_m
    wire [DW-1:0] avg8 = acc[i][AW-1:AW-DW]; // R21
    wire [DW-1:0] refa = cfg[i].use_avg ? avg8 : refr[i]; // R9
    wire [DW-1:0] m = res[i];
    wire [DW-1:0] dabs = (m >= refa) ? m - refa : refa - m;
    wire [AW:0] diff = {1'b0, acc[i]} - {1'b0, m, 2'b00}; // R13
    wire signed [AW:0] step = $signed(diff) >>> ({1'b0, cfg[i].wsel} + 3'd1); // R10
    wire [AW-1:0] next_acc = acc[i] - step[AW-1:0]; // R12
    wire me = eval & (sel == i);
    assign hit[i] = me & init_done[i] & ({4'h0, dabs} > {4'h0, cfg[i].thr}); // R8
    wire upd = me & init_done[i] & (!hit[i] | cfg[i].inc); // R15

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg[i] <= `LPW_CFG_RST;
        refr[i] <= '0;
        acc[i] <= '0;
        res[i] <= '0;
        init_done[i] <= 1'b0;
      end else if (c_def) begin
        cfg[i] <= `LPW_CFG_RST;
        refr[i] <= '0;
        acc[i] <= '0;
        init_done[i] <= 1'b0;
      end else begin
        if (w_mth && w_msel == i && w_mreg == `LPW_R_CFG)
          cfg[i] <= hwdata[7:0]; // R10
        if (w_mth && w_msel == i && w_mreg == `LPW_R_REF)
          refr[i] <= hwdata[DW-1:0]; // R7
        if (in_field && sel == i && adc_done)
          res[i] <= adc_data; // R7
        if (wake_ent && !init_done[i] && refr[i] != '0) begin
          acc[i] <= {refr[i], 2'b00}; // R14
          init_done[i] <= 1'b1;
        end else if (me && !init_done[i]) begin
          acc[i] <= {m, 2'b00}; // R14
          init_done[i] <= 1'b1;
        end else if (upd) begin
          acc[i] <= next_acc; // R12
        end
      end
    end

    chk_avg_toward: assert property (@(posedge hclk) disable iff (!hresetn)
      upd && (acc[i] > {m, 2'b00}) |=> acc[i] <= $past(acc[i]))
      else $error("average moved away from result"); // R12
  end

  // ----------------------------------------
  // interrupt flags, set wins over read-clear
  // ----------------------------------------
  wire tmr_flag = tmr_exp & !wake;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irqf <= 3'h0;
    else if (c_def)
      irqf <= 3'h0;
    else begin
      irqf[`LPW_I_AMP] <= hit[0] | (irqf[`LPW_I_AMP] & !rd_irq); // R20
      irqf[`LPW_I_PH] <= hit[1] | (irqf[`LPW_I_PH] & !rd_irq); // R20
      irqf[`LPW_I_WT] <= tmr_flag | (irqf[`LPW_I_WT] & !rd_irq); // R18
    end
  end
  assign irq = |irqf; // R4

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] next_rd;
  wire rmsel = ra[4];
  always_comb begin
    next_rd = 32'h0000_0000;
    if (ra[7:5] == `LPW_MB_HI) begin
      unique case (ra[3:2])
        `LPW_R_CFG: next_rd[7:0] = cfg[rmsel];
        `LPW_R_REF: next_rd[DW-1:0] = refr[rmsel];
        `LPW_R_AVG: next_rd[DW-1:0] = acc[rmsel][AW-1:AW-DW]; // R21
        `LPW_R_RES: next_rd[DW-1:0] = res[rmsel];
      endcase
    end else begin
      unique case (ra)
        `LPW_A_OP: next_rd[0] = wake;
        `LPW_A_WTC: next_rd[4:0] = wtc;
        `LPW_A_IRQ: next_rd[2:0] = irqf;
        `LPW_A_ADC: next_rd[DW-1:0] = adc_out; // R19
        default: next_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (acc_ok && !hwrite)
      hrdata <= next_rd;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_entry;
    $past(w_op) && $past(hwdata) == `LPW_OP_WAKE;
  endsequence
  chk_wake_entry: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    $rose(wake) |-> s_entry)
    else $error("wake-up mode entered without a clean write");
  chk_field_len: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    in_field |-> on_cnt < FIELD_CYC)
    else $error("field stayed on too long");
  chk_sched_wake: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    $rose(in_field) |-> $past(wake))
    else $error("measurement outside wake-up mode");
  chk_meas_enabled: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    meas.start |-> (sel ? ph_en : amp_en))
    else $error("disabled method measured");
  chk_irq_cause: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    $rose(irqf[`LPW_I_AMP]) |-> $past(eval) && !$past(sel) && $past(hit[0]))
    else $error("amplitude flag without a detection");
  chk_irq_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    irqf[`LPW_I_PH] && !rd_irq && !c_def |=> irqf[`LPW_I_PH])
    else $error("phase flag lost before read");
  chk_stop_all: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    c_stop |=> !tmr_run ##1 (state != lpw_pkg::LPW_FIELD))
    else $error("timer kept running after stop");
  chk_wt_flag: assert property (@(posedge hclk) disable iff (!hresetn) // R18
    tmr_flag && !c_def && !c_wt |=> irqf[`LPW_I_WT] && !tmr_run)
    else $error("timer expiry not flagged");
endmodule : lpw_wakeup

// ==== rtl/lpw_defines.svh ====
// constants of the card-presence wake-up block
// assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus
`ifndef LPW_DEFINES_SVH
`define LPW_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LPW_A_OP 8'h00
`define LPW_A_CMD 8'h04
`define LPW_A_WTC 8'h08
`define LPW_A_IRQ 8'h0C
`define LPW_A_ADC 8'h10
`define LPW_MB_HI 3'h1
`define LPW_R_CFG 2'h0
`define LPW_R_REF 2'h1
`define LPW_R_AVG 2'h2
`define LPW_R_RES 2'h3
// ----------------------------------------
// values and fields
// ----------------------------------------
`define LPW_OP_WAKE 32'h0000_0001
`define LPW_CMD_STOP 8'h01
`define LPW_CMD_WT 8'h02
`define LPW_CMD_DEF 8'h03
`define LPW_WTC_RST 5'h03
`define LPW_CFG_RST 8'h00
`define LPW_AMP_EN 3
`define LPW_PH_EN 4
`define LPW_I_AMP 0
`define LPW_I_PH 1
`define LPW_I_WT 2
// ----------------------------------------
// timing
// ----------------------------------------
`define LPW_CLK_KHZ 100000
`define LPW_RC_KHZ 32
`define LPW_FIELD_NS 20000
`define LPW_CLK_NS 10
// wake-up interval in 32 kHz ticks, one entry per interval code
`define LPW_WT_TOP '{15'h0140, 15'h0280, 15'h0640, 15'h0C80, \
  15'h1900, 15'h3200, 15'h4B00, 15'h6400}
`endif

// ==== rtl/lpw_pkg.sv ====
// types of the card-presence wake-up block
// assumes lpw_defines.svh for all numbers
package lpw_pkg;
  typedef struct packed {
    logic inc;
    logic use_avg;
    logic [1:0] wsel;
    logic [3:0] thr;
  } lpw_cfg_t;
  typedef struct packed {
    logic start;
    logic method;
    logic field_on;
  } lpw_meas_t;
  typedef enum logic [1:0] {
    LPW_IDLE = 2'b00,
    LPW_WAIT = 2'b01,
    LPW_FIELD = 2'b11,
    LPW_EVAL = 2'b10
  } lpw_state_t;
endpackage : lpw_pkg

// ==== dv/lpw_adc_model.sv ====
// converter model facing the wake-up block's measurement port
// assumes one hclk domain; the bench sets the value and the answer delay
`timescale 1ns/100ps
module lpw_adc_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // request from the block
  input lpw_pkg::lpw_meas_t meas,
  // bench controls
  input wire logic [7:0] value,
  input wire logic [3:0] delay,
  // answer
  output logic adc_done,
  output logic [7:0] adc_data
);
  logic busy;
  logic [3:0] cnt;
  // ----------------------------------------
  // conversion
  // ----------------------------------------
  // data toggles outside the done cycle so a late sample never looks valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'h0;
      cnt <= 4'h0;
      adc_done <= 1'h0;
      adc_data <= 8'h00;
    end else begin
      adc_done <= 1'h0;
      adc_data <= ~adc_data;
      if (meas.start) begin
        busy <= 1'h1;
        cnt <= delay;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'h0;
        adc_done <= 1'h1;
        adc_data <= value;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : lpw_adc_model

// ==== dv/testbench.sv ====
// self-checking bench of the card-presence wake-up block
// assumes the converter model and a zero-wait AHB-Lite slave
`timescale 1ns/100ps
`include "lpw_defines.svh"
module testbench;
  localparam int FC = 16;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] mval = 8'h00;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic adc_done;
  wire logic [7:0] adc_data;
  wire logic irq;
  lpw_pkg::lpw_meas_t meas;
  int error_cnt = 0;
  int comparisons = 0;
  time t_start;
  logic [31:0] rd;
  logic ok;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  // short divider and field window keep the run small
  lpw_wakeup #(.RC_DIV(8), .FIELD_CYC(FC)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas(meas), .adc_done(adc_done), .adc_data(adc_data), .irq(irq));
  lpw_adc_model adc_u (.hclk(hclk), .hresetn(hresetn), .meas(meas), .value(mval),
    .delay(4'h4), .adc_done(adc_done), .adc_data(adc_data));
  always #5 hclk = ~hclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] ma(input logic m, input logic [1:0] r);
    return {`LPW_MB_HI, m, r, 2'h0};
  endfunction : ma
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask : wr
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    check(name, rd, exp);
  endtask : rdc
  // waits for one measurement, then lets its evaluation settle
  task automatic wait_meas(input logic m, output logic seen);
    int n;
    int len;
    seen = 1'h0;
    len = 0;
    for (n = 0; n < 3000 && !seen; n++) begin
      @(posedge hclk);
      seen = (meas.start === 1'h1);
    end
    if (seen) begin
      t_start = $time;
      check("method", {31'h0, meas.method}, {31'h0, m});
      while (meas.field_on === 1'h1 && len < 40) begin
        @(posedge hclk);
        len++;
      end
      check("field_len", {31'h0, len <= FC}, 32'h1);
      repeat (4) @(posedge hclk);
    end
  endtask : wait_meas
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc("wtc_rst", `LPW_A_WTC, 32'h3);
    rdc("cfg_rst", ma(1'h1, `LPW_R_CFG), 32'h0);
    rdc("irq_rst", `LPW_A_IRQ, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_entry();
    wr(`LPW_A_WTC, 32'h08);
    wr(`LPW_A_OP, 32'h3);
    wait_meas(1'h0, ok);
    check("no_entry", {31'h0, ok}, 32'h0);
    wr(`LPW_A_OP, 32'h0);
    $display("test entry done");
  endtask : t_entry
  task automatic t_host_ref();
    time t1;
    wr(ma(1'h0, `LPW_R_CFG), 32'h04);
    wr(ma(1'h0, `LPW_R_REF), 32'h80);
    mval <= 8'h84;
    wr(`LPW_A_OP, `LPW_OP_WAKE);
    wait_meas(1'h0, ok);
    t1 = t_start;
    check("irq_at_thr", {31'h0, irq}, 32'h0);
    rdc("result", ma(1'h0, `LPW_R_RES), 32'h84);
    rdc("adc", `LPW_A_ADC, 32'h84);
    rdc("cfg_rb", ma(1'h0, `LPW_R_CFG), 32'h04);
    mval <= 8'h85;
    wait_meas(1'h0, ok);
    check("period", {31'h0, (t_start - t1) >= 24000 && (t_start - t1) <= 27200}, 32'h1);
    check("irq_above", {31'h0, irq}, 32'h1);
    rdc("irq_amp", `LPW_A_IRQ, 32'h1);
    check("irq_clr", {31'h0, irq}, 32'h0);
    $display("test host reference done");
  endtask : t_host_ref
  task automatic t_average();
    wr(`LPW_A_CMD, {24'h0, `LPW_CMD_DEF});
    wr(ma(1'h1, `LPW_R_CFG), 32'h4F);
    wr(`LPW_A_WTC, 32'h10);
    mval <= 8'h40;
    wr(`LPW_A_OP, `LPW_OP_WAKE);
    wait_meas(1'h1, ok);
    check("seed_irq", {31'h0, irq}, 32'h0);
    rdc("avg_seed", ma(1'h1, `LPW_R_AVG), 32'h40);
    mval <= 8'h48;
    wait_meas(1'h1, ok);
    rdc("avg_upd", ma(1'h1, `LPW_R_AVG), 32'h44);
    mval <= 8'h80;
    wait_meas(1'h1, ok);
    rdc("irq_ph", `LPW_A_IRQ, 32'h2);
    rdc("avg_excl", ma(1'h1, `LPW_R_AVG), 32'h44);
    wr(`LPW_A_OP, 32'h0);
    wr(ma(1'h1, `LPW_R_CFG), 32'hFF);
    mval <= 8'h84;
    wr(`LPW_A_OP, `LPW_OP_WAKE);
    wait_meas(1'h1, ok);
    rdc("avg_incl", ma(1'h1, `LPW_R_AVG), 32'h48);
    rdc("irq_incl", `LPW_A_IRQ, 32'h2);
    $display("test averaging done");
  endtask : t_average
  task automatic t_timer();
    int n;
    wr(`LPW_A_CMD, {24'h0, `LPW_CMD_STOP});
    wait_meas(1'h1, ok);
    check("stop_wake", {31'h0, ok}, 32'h0);
    wr(`LPW_A_OP, 32'h0);
    wr(`LPW_A_CMD, {24'h0, `LPW_CMD_WT});
    for (n = 0; n < 3000 && irq !== 1'h1; n++) @(posedge hclk);
    rdc("wt_flag", `LPW_A_IRQ, 32'h4);
    wr(`LPW_A_CMD, {24'h0, `LPW_CMD_WT});
    wr(`LPW_A_CMD, {24'h0, `LPW_CMD_STOP});
    repeat (3000) @(posedge hclk);
    check("stop_wt", {31'h0, irq}, 32'h0);
    $display("test timer done");
  endtask : t_timer
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_entry();
    t_host_ref();
    t_average();
    t_timer();
    end_sim();
  end
endmodule : testbench
